// ===== rtl/rpp_stage.v
// reverse power protection stage with apb registers, events and fault history
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "rpp_map.vh"
module rpp_stage #(
    parameter CYC_1MS = `RPP_CLK_MHZ * `RPP_MS_US
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [15:0] irms_l1,
    input wire [15:0] irms_l2,
    input wire [15:0] irms_l3,
    input wire [15:0] urms_1,
    input wire [15:0] urms_2,
    input wire [15:0] urms_3,
    input wire [15:0] urms_4,
    input wire [23:0] measured_active_power,
    input wire block_in,
    output reg start_o,
    output reg trip_o,
    output reg blocked_o,
    output reg ev_valid,
    output reg [2:0] ev_code,
    output reg [31:0] ev_stamp
);
// ****************************************
// state and storage
// ****************************************
localparam S_IDLE = 3'b001;
localparam S_DIV = 3'b010;
localparam S_EVAL = 3'b100;
reg [2:0] st_q;
reg [19:0] msdiv_q;
reg [2:0] tb_q;
reg [31:0] time_q;
reg [2:0] mode_q;
reg frc_en_q;
reg [1:0] frc_q;
reg [2:0] grp_q;
reg [5:0] evsel_q;
reg [18:0] delay_q;
reg [23:0] pu_q [0:7];
reg [15:0] rms_q [0:6];
reg blk_s_q;
reg [23:0] pm_q;
reg [31:0] dvd_q;
reg [32:0] rem_q;
reg [31:0] quo_q;
reg [5:0] step_q;
reg [16:0] ratio_q;
reg pick_q, start_q, trip_q, blkd_q;
reg [18:0] elap_q;
reg [23:0] ring_q [0:`RPP_RING_N-1];
reg [5:0] rptr_q;
reg [23:0] pref_q;
reg [5:0] pend_q;
reg [31:0] stamp_q;
reg [15:0] cnt_st_q, cnt_tr_q, cnt_bl_q;
reg [2:0] rpend_q;
reg [23:0] r_pre_q, r_flt_q;
reg [18:0] r_rem_q;
reg [3:0] hptr_q;
reg [3:0] hsel_q;
reg [31:0] h_time_q [0:`RPP_HIST_N-1];
reg [5:0] h_info_q [0:`RPP_HIST_N-1];
reg [23:0] h_pre_q [0:`RPP_HIST_N-1];
reg [23:0] h_flt_q [0:`RPP_HIST_N-1];
reg [23:0] h_pref_q [0:`RPP_HIST_N-1];
reg [18:0] h_rem_q [0:`RPP_HIST_N-1];
integer i, k;
// ****************************************
// time base
// ****************************************
wire ms_tick = (msdiv_q == CYC_1MS - 1);
wire tick5 = ms_tick && (tb_q == `RPP_TBASE_MS - 3'd1);
wire wr_acc = psel && penable && pwrite && pready && !pslverr; // refused writes never land
wire [7:0] wa = paddr[7:0];
// 1 ms stamp counter; software may load it with wall time
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        msdiv_q <= 20'h00000;
        tb_q <= 3'h0;
        time_q <= 32'h00000000;
    end else begin
        msdiv_q <= ms_tick ? 20'h00000 : msdiv_q + 20'h00001;
        if (ms_tick)
            tb_q <= (tb_q == `RPP_TBASE_MS - 3'd1) ? 3'h0 : tb_q + 3'h1;
        if (wr_acc && wa == `RPP_A_TIME)
            time_q <= pwdata;
        else if (ms_tick)
            time_q <= time_q + 32'h00000001;
    end
end
// ****************************************
// processing cycle: sample, divide, evaluate
// ****************************************
wire [23:0] pset = pu_q[grp_q];
wire [32:0] rem_sh = {rem_q[31:0], dvd_q[31]};
wire rem_ge = rem_sh >= {9'h000, pset};
// restoring divider: 32 steps fit easily inside the 5 ms cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        st_q <= S_IDLE;
        blk_s_q <= 1'b0;
        pm_q <= 24'h000000;
        dvd_q <= 32'h00000000;
        rem_q <= 33'h000000000;
        quo_q <= 32'h00000000;
        step_q <= 6'h00;
        ratio_q <= 17'h00000;
    end else begin
        case (st_q)
            S_IDLE: begin
                if (tick5) begin
                    blk_s_q <= block_in;
                    pm_q <= measured_active_power;
                    dvd_q <= {8'h00, measured_active_power} * {24'h000000, `RPP_RATIO_SCALE};
                    rem_q <= 33'h000000000;
                    quo_q <= 32'h00000000;
                    step_q <= 6'h00;
                    st_q <= S_DIV;
                end
            end
            S_DIV: begin
                dvd_q <= {dvd_q[30:0], 1'b0};
                rem_q <= rem_ge ? rem_sh - {9'h000, pset} : rem_sh;
                quo_q <= {quo_q[30:0], rem_ge};
                step_q <= step_q + 6'h01;
                if (step_q == `RPP_DIV_STEPS - 6'h01)
                    st_q <= S_EVAL;
            end
            S_EVAL: begin
                // a zero level or huge power saturates at the display limit
                ratio_q <= (pset == 24'h000000 || quo_q > {15'h0000, `RPP_RATIO_MAX}) ?
                    `RPP_RATIO_MAX : quo_q[16:0];
                st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
        endcase
    end
end
// ****************************************
// pick-up, blocking and definite-time delay
// ****************************************
wire [16:0] ratio_now = (pset == 24'h000000 || quo_q > {15'h0000, `RPP_RATIO_MAX}) ?
    `RPP_RATIO_MAX : quo_q[16:0];
wire m_off = (mode_q > `RPP_MODE_TBLK);
wire m_blk = (mode_q == `RPP_MODE_BLK) || (mode_q == `RPP_MODE_TBLK);
wire pick_d = !m_off && (pick_q ? (ratio_now >= `RPP_RATIO_RST)
    : (ratio_now >= `RPP_RATIO_PU));
wire blk_now = blk_s_q || m_blk;
wire start_d = pick_d && !blk_now;
wire blkd_d = pick_d && blk_now;
wire [18:0] elap_d = start_d ? elap_q + 19'h00001 : 19'h00000;
wire trip_d = start_d && (elap_d >= delay_q);
wire eval = (st_q == S_EVAL);
wire [5:0] ev_new = {blkd_q & !blkd_d, !blkd_q & blkd_d, trip_q & !trip_d,
    !trip_q & trip_d, start_q & !start_d, !start_q & start_d};
wire [5:0] pre_idx = (rptr_q >= `RPP_PRE_TRIG_N) ? rptr_q - `RPP_PRE_TRIG_N
    : rptr_q + `RPP_RING_LAST + 6'h01 - `RPP_PRE_TRIG_N;
wire [18:0] remain = (delay_q > elap_q) ? delay_q - elap_q : 19'h00000;
// only one stage exists; its state is updated once per processing cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pick_q <= 1'b0;
        start_q <= 1'b0;
        trip_q <= 1'b0;
        blkd_q <= 1'b0;
        elap_q <= 19'h00000;
        rptr_q <= 6'h00;
        pref_q <= 24'h000000;
        stamp_q <= 32'h00000000;
        r_pre_q <= 24'h000000;
        r_flt_q <= 24'h000000;
        r_rem_q <= 19'h00000;
        for (k = 0; k < `RPP_RING_N; k = k + 1)
            ring_q[k] <= 24'h000000;
    end else if (eval) begin
        pick_q <= pick_d;
        start_q <= start_d;
        trip_q <= trip_d;
        blkd_q <= blkd_d;
        elap_q <= elap_d;
        // slot at the write pointer still holds the sample from 200 ms ago
        ring_q[rptr_q] <= pm_q;
        rptr_q <= (rptr_q == `RPP_RING_LAST) ? 6'h00 : rptr_q + 6'h01;
        if (ev_new[0])
            pref_q <= ring_q[rptr_q];
        stamp_q <= time_q;
        r_pre_q <= ring_q[pre_idx];
        r_flt_q <= pm_q;
        r_rem_q <= trip_d ? 19'h00000 : delay_q - elap_d;
    end
end
// ****************************************
// events, counters and history
// ****************************************
wire [5:0] ev_pick = pend_q & (~pend_q + 6'h01);
wire [2:0] rec_pick = rpend_q & (~rpend_q + 3'h1);
wire clr_cnt = wr_acc && wa == `RPP_A_CTRL && pwdata[`RPP_CTRL_CLR];
wire [2:0] ev_enc = ev_pick[1] ? 3'h1 : ev_pick[2] ? 3'h2 : ev_pick[3] ? 3'h3
    : ev_pick[4] ? 3'h4 : ev_pick[5] ? 3'h5 : 3'h0;
// events queue one per cycle; a new event sets its bit even while draining
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pend_q <= 6'h00;
        rpend_q <= 3'h0;
        ev_valid <= 1'b0;
        ev_code <= 3'h0;
        ev_stamp <= 32'h00000000;
        cnt_st_q <= 16'h0000;
        cnt_tr_q <= 16'h0000;
        cnt_bl_q <= 16'h0000;
        hptr_q <= 4'h0;
    end else begin
        pend_q <= (pend_q & ~ev_pick) | (eval ? ev_new & evsel_q : 6'h00);
        rpend_q <= (rpend_q & ~rec_pick) |
            (eval ? {ev_new[4], ev_new[2], ev_new[0]} : 3'h0);
        ev_valid <= |pend_q;
        ev_code <= ev_enc;
        ev_stamp <= stamp_q;
        // a count in the clearing cycle is kept: the increment wins
        cnt_st_q <= (clr_cnt ? 16'h0000 : cnt_st_q) + {15'h0000, eval & ev_new[0]};
        cnt_tr_q <= (clr_cnt ? 16'h0000 : cnt_tr_q) + {15'h0000, eval & ev_new[2]};
        cnt_bl_q <= (clr_cnt ? 16'h0000 : cnt_bl_q) + {15'h0000, eval & ev_new[4]};
        if (|rpend_q) begin
            h_time_q[hptr_q] <= stamp_q;
            h_info_q[hptr_q] <= {grp_q, rec_pick[0] ? 3'h0 : rec_pick[1] ? 3'h2 : 3'h4};
            h_pre_q[hptr_q] <= r_pre_q;
            h_flt_q[hptr_q] <= r_flt_q;
            h_pref_q[hptr_q] <= pref_q;
            h_rem_q[hptr_q] <= r_rem_q;
            hptr_q <= (hptr_q == `RPP_HIST_LAST) ? 4'h0 : hptr_q + 4'h1;
        end
    end
end
// ****************************************
// outputs with forcing
// ****************************************
// forcing overrides the pins only; events and counters follow the real state
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        start_o <= 1'b0;
        trip_o <= 1'b0;
        blocked_o <= 1'b0;
    end else if (frc_en_q) begin
        start_o <= (frc_q == `RPP_FRC_START) || (frc_q == `RPP_FRC_TRIP);
        trip_o <= (frc_q == `RPP_FRC_TRIP);
        blocked_o <= (frc_q == `RPP_FRC_BLK);
    end else begin
        start_o <= start_q;
        trip_o <= trip_q;
        blocked_o <= blkd_q;
    end
end
// ****************************************
// apb slave
// ****************************************
wire [1:0] cond = trip_q ? 2'h2 : blkd_q ? 2'h3 : start_q ? 2'h1 : 2'h0;
reg [31:0] rd_d;
reg err_d;
// read mux; unmapped addresses answer zero with an error
always @* begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    case (wa)
        `RPP_A_CTRL: rd_d = {22'h0, 1'b0, grp_q, frc_q, frc_en_q, mode_q};
        `RPP_A_EVSEL: rd_d = {26'h0, evsel_q};
        `RPP_A_DELAY: rd_d = {13'h0, delay_q};
        `RPP_A_TIME: rd_d = time_q;
        `RPP_A_STAT: rd_d = {22'h0, hptr_q, mode_q, pick_q, cond};
        `RPP_A_RATIO: rd_d = {15'h0, ratio_q};
        `RPP_A_EXPECT: rd_d = {13'h0, delay_q};
        `RPP_A_REMAIN: rd_d = {13'h0, start_q ? remain : delay_q};
        `RPP_A_CNT_ST: rd_d = {16'h0, cnt_st_q};
        `RPP_A_CNT_TR: rd_d = {16'h0, cnt_tr_q};
        `RPP_A_CNT_BL: rd_d = {16'h0, cnt_bl_q};
        `RPP_A_HSEL: rd_d = {28'h0, hsel_q};
        `RPP_A_H_TIME: rd_d = h_time_q[hsel_q];
        `RPP_A_H_INFO: rd_d = {26'h0, h_info_q[hsel_q]};
        `RPP_A_H_PRE: rd_d = {8'h0, h_pre_q[hsel_q]};
        `RPP_A_H_FLT: rd_d = {8'h0, h_flt_q[hsel_q]};
        `RPP_A_H_PREF: rd_d = {8'h0, h_pref_q[hsel_q]};
        `RPP_A_H_REM: rd_d = {13'h0, h_rem_q[hsel_q]};
        default: begin
            if (wa[7:5] == `RPP_A_PU_HI)
                rd_d = {8'h0, pu_q[wa[4:2]]};
            else if (wa[7:5] == `RPP_A_RMS_HI && wa[4:2] != 3'h7)
                rd_d = {16'h0, rms_q[wa[4:2]]};
            else
                err_d = 1'b1;
        end
    endcase
    // bits outside the decoded word must never alias onto a register
    if (paddr[31:8] != 24'h000000 || paddr[1:0] != 2'h0) begin
        err_d = 1'b1;
        rd_d = 32'h00000000;
    end
end
// zero wait: answer registered in setup, pready high through the access cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        mode_q <= `RPP_MODE_ON;
        frc_en_q <= 1'b0;
        frc_q <= 2'h0;
        grp_q <= 3'h0;
        evsel_q <= `RPP_EVSEL_RST;
        delay_q <= `RPP_DELAY_RST;
        hsel_q <= 4'h0;
        for (i = 0; i < 8; i = i + 1)
            pu_q[i] <= `RPP_PU_RST;
        for (i = 0; i < 7; i = i + 1)
            rms_q[i] <= 16'h0000;
    end else begin
        pready <= psel && !penable;
        pslverr <= psel && !penable && err_d;
        prdata <= (psel && !penable && !pwrite) ? rd_d : 32'h00000000;
        if (tick5 && st_q == S_IDLE) begin
            rms_q[0] <= irms_l1;
            rms_q[1] <= irms_l2;
            rms_q[2] <= irms_l3;
            rms_q[3] <= urms_1;
            rms_q[4] <= urms_2;
            rms_q[5] <= urms_3;
            rms_q[6] <= urms_4;
        end
        if (wr_acc && !pslverr) begin
            if (wa == `RPP_A_CTRL) begin
                mode_q <= pwdata[2:0];
                frc_en_q <= pwdata[3];
                frc_q <= pwdata[5:4];
                grp_q <= pwdata[8:6];
            end
            if (wa == `RPP_A_EVSEL)
                evsel_q <= pwdata[5:0];
            if (wa == `RPP_A_DELAY)
                delay_q <= pwdata[18:0];
            if (wa == `RPP_A_HSEL)
                hsel_q <= (pwdata[3:0] > `RPP_HIST_LAST) ? `RPP_HIST_LAST : pwdata[3:0];
            if (wa[7:5] == `RPP_A_PU_HI)
                pu_q[wa[4:2]] <= pwdata[23:0];
        end
    end
end
endmodule // rpp_stage
`default_nettype wire

// ===== rtl/rpp_map.vh
// constants for the reverse power protection stage
`ifndef RPP_MAP_VH
`define RPP_MAP_VH
// ****************************************
// timing
// ****************************************
`define RPP_CLK_MHZ 125
`define RPP_MS_US 1000
`define RPP_TBASE_MS 3'd5
`define RPP_PRE_TRIG_MS 20
`define RPP_PRE_FLT_MS 200
`define RPP_PRE_TRIG_N 6'd4
`define RPP_RING_N 40
`define RPP_RING_LAST 6'd39
// ****************************************
// ratio in units of 0.01 pm/pset
// ****************************************
`define RPP_RATIO_PU 17'h00064
`define RPP_RATIO_RST 17'h00061
`define RPP_RATIO_MAX 17'h1E848
`define RPP_RATIO_SCALE 8'h64
`define RPP_DIV_STEPS 6'h20
// ****************************************
// register byte addresses
// ****************************************
`define RPP_A_CTRL 8'h00
`define RPP_A_EVSEL 8'h04
`define RPP_A_DELAY 8'h08
`define RPP_A_TIME 8'h0C
`define RPP_A_STAT 8'h10
`define RPP_A_RATIO 8'h14
`define RPP_A_EXPECT 8'h18
`define RPP_A_REMAIN 8'h1C
`define RPP_A_CNT_ST 8'h20
`define RPP_A_CNT_TR 8'h24
`define RPP_A_CNT_BL 8'h28
`define RPP_A_HSEL 8'h2C
`define RPP_A_H_TIME 8'h30
`define RPP_A_H_INFO 8'h34
`define RPP_A_H_PRE 8'h38
`define RPP_A_H_FLT 8'h3C
`define RPP_A_H_PREF 8'h40
`define RPP_A_H_REM 8'h44
`define RPP_A_PU_HI 3'h3
`define RPP_A_RMS_HI 3'h4
// ****************************************
// fields and reset values
// ****************************************
`define RPP_CTRL_CLR 9
`define RPP_MODE_ON 3'h0
`define RPP_MODE_BLK 3'h1
`define RPP_MODE_TEST 3'h2
`define RPP_MODE_TBLK 3'h3
`define RPP_FRC_START 2'h1
`define RPP_FRC_TRIP 2'h2
`define RPP_FRC_BLK 2'h3
`define RPP_EVSEL_RST 6'h3F
`define RPP_DELAY_RST 19'h00028
`define RPP_PU_RST 24'h002710
`define RPP_HIST_N 12
`define RPP_HIST_LAST 4'hB
`endif

// ===== verification/rpp_stage_chk.sv
// port checker for the reverse power protection stage
`timescale 1ns/100ps
`default_nettype none
module rpp_stage_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic start_o,
    input wire logic trip_o,
    input wire logic blocked_o,
    input wire logic ev_valid,
    input wire logic [2:0] ev_code,
    input wire logic [31:0] ev_stamp
);
    // ****************************************
    // port relations
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // zero-wait slave: answer always the cycle after setup, for one cycle
    AST_ZERO_WAIT: assert property (psel && !penable |=> pready) else $error("no ready");
    AST_ONE_ACCESS: assert property (pready |=> !pready) else $error("ready too long");
    AST_IDLE_RDATA: assert property (!pready |-> prdata == 32'h0) else $error("idle data");
    AST_BAD_ADDR: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned accepted");
    AST_ERR_IN_ACCESS: assert property (pslverr |-> pready) else $error("stray error");
    // forced trip raises start as well, so trip alone never shows
    AST_TRIP_WITH_START: assert property (trip_o |-> start_o) else $error("trip alone");
    AST_NO_START_BLOCKED: assert property (!(start_o && blocked_o)) else $error("both");
    AST_EV_CODE: assert property (ev_valid |-> ev_code <= 3'h5) else $error("bad code");
    // events of one evaluation leave lowest code first with one stamp
    AST_EV_ORDER: assert property (ev_valid ##1 ev_valid |-> ev_code > $past(ev_code))
        else $error("event order");
    AST_EV_STAMP: assert property (ev_valid ##1 ev_valid |-> $stable(ev_stamp))
        else $error("stamp moved");
endmodule // rpp_stage_chk
bind rpp_stage rpp_stage_chk u_rpp_stage_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .ev_valid(ev_valid),
    .ev_code(ev_code), .ev_stamp(ev_stamp));
`default_nettype wire

// ===== verification/rpp_meas_model.sv
// measurement subsystem and blocking matrix model feeding the stage
`timescale 1ns/100ps
`default_nettype none
module rpp_meas_model (
    input wire logic pclk,
    input wire logic [23:0] pwr_req,
    input wire logic blk_req,
    output logic [15:0] irms_l1 = 16'h0,
    output logic [15:0] irms_l2 = 16'h0,
    output logic [15:0] irms_l3 = 16'h0,
    output logic [15:0] urms_1 = 16'h0,
    output logic [15:0] urms_2 = 16'h0,
    output logic [15:0] urms_3 = 16'h0,
    output logic [15:0] urms_4 = 16'h0,
    output logic [23:0] measured_active_power = 24'h0,
    output logic block_in = 1'b0
);
    // ****************************************
    // refreshed quantities
    // ****************************************
    // refreshed every clock so any 5 ms sample sees current values
    always @(posedge pclk) begin
        measured_active_power <= pwr_req;
        irms_l1 <= pwr_req[15:0];
        irms_l2 <= ~pwr_req[15:0];
        irms_l3 <= pwr_req[15:0] ^ 16'h00FF;
        {urms_1, urms_2, urms_3, urms_4} <= {4{16'h0E66}};
    end
    // blocking follows blk_req one clock later, with no lead over the operate delay
    always @(posedge pclk) block_in <= blk_req;
endmodule // rpp_meas_model
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the reverse power protection stage
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // ****************************************
    // bench
    // ****************************************
    localparam int CYC = 20;
    localparam int TICK = 5 * CYC;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, blk_req = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, ev_stamp;
    logic [23:0] pwr_req = 24'h0, pwr;
    logic pready, pslverr, start_o, trip_o, blocked_o, ev_valid, blk;
    logic [2:0] ev_code;
    logic [15:0] il1, il2, il3, u1, u2, u3, u4;
    logic [2:0] evq[$];
    logic [31:0] stq[$];
    int num_errors = 0, compares = 0, cyc;
    always #4 pclk = ~pclk;
    rpp_meas_model u_rpp_meas_model (.pclk(pclk), .pwr_req(pwr_req), .blk_req(blk_req),
        .irms_l1(il1), .irms_l2(il2), .irms_l3(il3), .urms_1(u1), .urms_2(u2), .urms_3(u3),
        .urms_4(u4), .measured_active_power(pwr), .block_in(blk));
    rpp_stage #(.CYC_1MS(CYC)) u_rpp_stage (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irms_l1(il1), .irms_l2(il2), .irms_l3(il3),
        .urms_1(u1), .urms_2(u2), .urms_3(u3), .urms_4(u4), .measured_active_power(pwr),
        .block_in(blk), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o),
        .ev_valid(ev_valid), .ev_code(ev_code), .ev_stamp(ev_stamp));
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // pready is taken at the rising edge, where the slave's answer is sampled
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [32:0] res);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, 24'h0, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        res = {pslverr, prdata};
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t no pready on bus", $time);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        logic [32:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask
    task automatic set_in(input logic [23:0] p, input logic b);
        @(posedge pclk);
        {pwr_req, blk_req} <= {p, b};
    endtask
    // waits at most a few evaluations for masked start, trip, blocked levels
    task automatic pins(input logic [2:0] exp, input logic [2:0] m, output int n);
        n = 0;
        while (({start_o, trip_o, blocked_o} & m) !== exp && n < 5 * TICK) begin
            @(negedge pclk);
            n++;
        end
        chk(33'({start_o, trip_o, blocked_o} & m), 33'(exp));
    endtask
    // collect each event pulse with its stamp
    always @(negedge pclk) begin
        if (ev_valid === 1'b1) begin
            evq.push_back(ev_code);
            stq.push_back(ev_stamp);
        end
    end
    // codes packed four bits apiece, oldest in the low nibble
    task automatic chk_ev(input int cnt, input logic [15:0] codes);
        repeat (12) @(negedge pclk);
        chk(33'(evq.size()), 33'(cnt));
        for (int i = 0; i < evq.size() && i < 4; i++) chk(33'(evq[i]), 33'(codes[4*i +: 3]));
        evq.delete();
    endtask
    task automatic end_of_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // cut a hang short well beyond the expected run
    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 33'h0);
        rd(8'h04, 33'h3F);
        rd(8'h08, 33'h28);
        rd(8'h60, 33'h2710);
        rd(8'h50, 33'h100000000);
        rd(8'h02, 33'h100000000);
        wr(8'h08, 32'h3);
        set_in(24'h2710, 1'b0);
        pins(3'b100, 3'b100, cyc);
        rd(8'h14, 33'h64);
        rd(8'h80, 33'h2710);
        pins(3'b110, 3'b111, cyc);
        chk(33'(cyc > 2 * TICK - 40 && cyc <= 3 * TICK + 5), 33'h1);
        rd(8'h24, 33'h1);
        wr(8'h2C, 32'h1);
        rd(8'h34, 33'h2);
        rd(8'h38, 33'h0);
        rd(8'h3C, 33'h2710);
        set_in(24'h25E4, 1'b0);
        repeat (3 * TICK) @(negedge pclk);
        pins(3'b110, 3'b111, cyc);
        set_in(24'h25E3, 1'b0);
        pins(3'b000, 3'b111, cyc);
        chk_ev(4, 16'h3120);
        wr(8'h08, 32'h28);
        set_in(24'h2710, 1'b1);
        pins(3'b001, 3'b111, cyc);
        set_in(24'h2710, 1'b0);
        pins(3'b100, 3'b110, cyc);
        set_in(24'h2710, 1'b1);
        pins(3'b000, 3'b110, cyc);
        rd(8'h20, 33'h2);
        wr(8'h00, 32'h200);
        rd(8'h20, 33'h0);
        set_in(24'h2710, 1'b0);
        wr(8'h00, 32'h1);
        pins(3'b001, 3'b111, cyc);
        wr(8'h00, 32'h4);
        pins(3'b000, 3'b111, cyc);
        wr(8'h00, 32'h0);
        pins(3'b100, 3'b101, cyc);
        rd(8'h18, 33'h28);
        rd(8'h1C, 33'h27);
        wr(8'h00, 32'h28);
        pins(3'b110, 3'b111, cyc);
        wr(8'h00, 32'h38);
        pins(3'b001, 3'b111, cyc);
        wr(8'h00, 32'h0);
        set_in(24'h0, 1'b0);
        pins(3'b000, 3'b111, cyc);
        wr(8'h64, 32'h1388);
        wr(8'h00, 32'h40);
        rd(8'h00, 33'h40);
        set_in(24'h1770, 1'b0);
        pins(3'b100, 3'b111, cyc);
        set_in(24'h0, 1'b0);
        pins(3'b000, 3'b111, cyc);
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h3);
        wr(8'h04, 32'h3E);
        repeat (12) @(negedge pclk);
        evq.delete();
        stq.delete();
        wr(8'h0C, 32'h10000);
        set_in(24'h2710, 1'b0);
        pins(3'b110, 3'b111, cyc);
        chk_ev(1, 16'h2);
        chk(33'(stq[0] - 32'h10000 < 32'h28), 33'h1);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
